// [common/exec_pkg.sv]
// Constants, register map and opcode patterns for the execute datapath
package exec_pkg;
  // Data and address widths
  localparam int DATA_W = 8;
  localparam int FADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int INSTR_W = 16;
  localparam int BUS_AW = 6;
  localparam int BUS_DW = 32;
  localparam int FILE_DEPTH = 4096;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [BUS_AW-1:0] ADDR_CTRL = 6'h00;
  localparam logic [BUS_AW-1:0] ADDR_INSTR = 6'h04;
  localparam logic [BUS_AW-1:0] ADDR_ACC = 6'h08;
  localparam logic [BUS_AW-1:0] ADDR_STATUS = 6'h0c;
  localparam logic [BUS_AW-1:0] ADDR_BANK = 6'h10;
  localparam logic [BUS_AW-1:0] ADDR_INDEX = 6'h14;
  localparam logic [BUS_AW-1:0] ADDR_POWER = 6'h18;
  localparam logic [BUS_AW-1:0] ADDR_MEM_ADDR = 6'h1c;
  localparam logic [BUS_AW-1:0] ADDR_MEM_DATA = 6'h20;

  // Control register fields
  localparam int CTRL_EXT_BIT = 0;

  // Status register fields
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam int ST_W = 5;

  // Power register fields
  localparam int PW_PD_N = 0;
  localparam int PW_TO_N = 1;
  localparam int PW_SLEEP = 2;
  localparam int PW_WAKE = 3;
  localparam int PW_WAKE_WDT = 4;

  // Instruction fields
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;

  // Opcode patterns
  localparam logic [5:0] OPC_ROTATE = 6'h10;
  localparam logic [6:0] OPC_SET_ONES = 7'h34;
  localparam logic [INSTR_W-1:0] OPC_SLEEP = 16'h0003;
  localparam logic [5:0] OPC_SUB_BORROW = 6'h15;
  localparam logic [7:0] OPC_SUB_LIT = 8'h08;
  localparam logic [5:0] OPC_SUB_FILE = 6'h17;

  // Addressing constants
  localparam logic [DATA_W-1:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [BANK_W-1:0] SFR_BANK = 4'hf;
  localparam logic [BANK_W-1:0] LOW_BANK = 4'h0;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;

  // Read wait stage at which read data stand
  localparam logic [1:0] RD_READY = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROTATE,
    OP_SET_ONES,
    OP_SLEEP,
    OP_SUB_BORROW,
    OP_SUB_LIT,
    OP_SUB_FILE
  } op_t;
endpackage : exec_pkg

// [hw/file_ram.sv]
// File register memory with registered read data
`timescale 1ns/1ps
module file_ram (
  input wire logic clock_in,
  input wire logic wr_en_in,
  input wire logic [exec_pkg::FADDR_W-1:0] wr_addr_in,
  input wire logic [exec_pkg::DATA_W-1:0] wr_data_in,
  input wire logic [exec_pkg::FADDR_W-1:0] rd_addr_in,
  output logic [exec_pkg::DATA_W-1:0] rd_data_out
);
  logic [exec_pkg::DATA_W-1:0] mem [exec_pkg::FILE_DEPTH];

  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // No reset on read data; contents are undefined until written
  always_ff @(posedge clock_in) begin
    rd_data_out <= mem[rd_addr_in];
  end
endmodule : file_ram

// [hw/rotate_set_subtract_sleep_exec.sv]
// Execute datapath for rotate, set, subtract and sleep instructions
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Rotate right without carry moves bit 0 into bit 7.
// RULE_02: Rotate changes only negative and zero flags.
// RULE_03: Destination bit 0 writes accumulator, 1 writes file register.
// RULE_04: Bank bit 0 uses access bank; 1 uses bank select register.
// RULE_05: Bank bit 0, extended mode, address up to 95 uses indexed offset.
// RULE_06: Set-all-ones writes ff to file register, flags untouched.
// RULE_07: Sleep clears powerdown bit, sets timeout bit, clears watchdog.
// RULE_08: Sleep entered in fourth phase with oscillator halted.
// RULE_09: Wake by watchdog time-out clears the timeout bit.
// RULE_10: Borrow subtract computes accumulator minus file minus inverted carry.
// RULE_11: Carry is an active-low borrow in subtraction.
// RULE_12: Literal subtract computes literal minus accumulator into accumulator.
// RULE_13: File subtract computes file minus accumulator into destination.
// RULE_14: Subtractions update negative, overflow, carry, digit carry, zero.
// RULE_15: One word, four phases: decode, read, process, write or sleep.
// RULE_16: Zero on zero result, negative is bit 7, usual subtract flags.
module rotate_set_subtract_sleep_exec (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [exec_pkg::BUS_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [exec_pkg::BUS_DW-1:0] avs_writedata_in,
  output logic [exec_pkg::BUS_DW-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic sleep_out,
  output logic watchdog_clear_out
);
  localparam int FLAG_W = exec_pkg::ST_W;

  exec_pkg::phase_t phase_r;
  exec_pkg::op_t op_r;
  logic [exec_pkg::INSTR_W-1:0] instr_r;
  logic [exec_pkg::DATA_W-1:0] acc_r;
  logic [FLAG_W-1:0] flags_r;
  logic [exec_pkg::BANK_W-1:0] bank_select_register_r;
  logic [exec_pkg::FADDR_W-1:0] index_base_r;
  logic ext_enable_r;
  logic powerdown_status_bit_r;
  logic timeout_status_bit_r;
  logic sleep_r;
  logic watchdog_clear_r;
  logic [exec_pkg::FADDR_W-1:0] mem_addr_r;
  logic [exec_pkg::FADDR_W-1:0] eff_addr_r;
  logic [exec_pkg::DATA_W-1:0] result_r;
  logic [FLAG_W-1:0] flags_nxt_r;
  logic to_acc_r;
  logic to_file_r;
  logic [1:0] rd_stage_r;
  logic [exec_pkg::BUS_DW-1:0] readdata_r;

  logic busy;
  logic bus_wr;
  logic [exec_pkg::FADDR_W-1:0] eff_addr;
  logic [exec_pkg::FADDR_W-1:0] ram_rd_addr;
  logic [exec_pkg::DATA_W-1:0] ram_q;
  logic ram_wr_en;
  logic [exec_pkg::FADDR_W-1:0] ram_wr_addr;
  logic [exec_pkg::DATA_W-1:0] ram_wr_data;
  logic [exec_pkg::DATA_W-1:0] result;
  logic [FLAG_W-1:0] flags_nxt;
  logic [exec_pkg::BUS_DW-1:0] read_mux;
  exec_pkg::op_t op_dec;

  // Subtract a - b with active-high carry-in; returns {ov, dc, c, res}
  function automatic logic [exec_pkg::DATA_W+2:0] sub8(
    input logic [exec_pkg::DATA_W-1:0] a,
    input logic [exec_pkg::DATA_W-1:0] b,
    input logic cin
  );
    logic [exec_pkg::DATA_W:0] full;
    logic [4:0] low;
    logic ov;
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin}; // RULE_11
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    ov = (a[7] != b[7]) && (full[7] != a[7]); // RULE_16
    sub8 = {ov, low[4], full[8], full[exec_pkg::DATA_W-1:0]};
  endfunction : sub8

  // Flags after an arithmetic result: Z and N from value, others given
  function automatic logic [FLAG_W-1:0] arith_flags(
    input logic [exec_pkg::DATA_W+2:0] s
  );
    logic [FLAG_W-1:0] f;
    f = '0;
    f[exec_pkg::ST_C] = s[exec_pkg::DATA_W];
    f[exec_pkg::ST_DC] = s[exec_pkg::DATA_W+1];
    f[exec_pkg::ST_OV] = s[exec_pkg::DATA_W+2];
    f[exec_pkg::ST_Z] = (s[exec_pkg::DATA_W-1:0] == 8'h00); // RULE_16
    f[exec_pkg::ST_N] = s[exec_pkg::DATA_W-1];
    arith_flags = f;
  endfunction : arith_flags

  assign busy = (phase_r != exec_pkg::PH_IDLE);
  // Bus requests stall while an instruction is in flight
  assign bus_wr = avs_write_in && !busy;
  assign avs_waitrequest_out = (avs_write_in && busy) ||
                               (avs_read_in && (busy || rd_stage_r != exec_pkg::RD_READY));
  assign avs_readdata_out = readdata_r;
  assign sleep_out = sleep_r;
  assign watchdog_clear_out = watchdog_clear_r;

  // Instruction decode
  always_comb begin
    op_dec = exec_pkg::OP_NONE;
    if (instr_r == exec_pkg::OPC_SLEEP) begin
      op_dec = exec_pkg::OP_SLEEP; // RULE_07
    end else if (instr_r[15:10] == exec_pkg::OPC_ROTATE) begin
      op_dec = exec_pkg::OP_ROTATE; // RULE_01
    end else if (instr_r[15:9] == exec_pkg::OPC_SET_ONES) begin
      op_dec = exec_pkg::OP_SET_ONES; // RULE_06
    end else if (instr_r[15:10] == exec_pkg::OPC_SUB_BORROW) begin
      op_dec = exec_pkg::OP_SUB_BORROW; // RULE_10
    end else if (instr_r[15:8] == exec_pkg::OPC_SUB_LIT) begin
      op_dec = exec_pkg::OP_SUB_LIT; // RULE_12
    end else if (instr_r[15:10] == exec_pkg::OPC_SUB_FILE) begin
      op_dec = exec_pkg::OP_SUB_FILE; // RULE_13
    end
  end

  // Effective file address
  always_comb begin
    if (instr_r[exec_pkg::A_BIT]) begin
      eff_addr = {bank_select_register_r, instr_r[7:0]}; // RULE_04
    end else if (ext_enable_r && instr_r[7:0] <= exec_pkg::ACCESS_LIMIT) begin
      eff_addr = index_base_r + {4'h0, instr_r[7:0]}; // RULE_05
    end else if (instr_r[7:0] <= exec_pkg::ACCESS_LIMIT) begin
      eff_addr = {exec_pkg::LOW_BANK, instr_r[7:0]}; // RULE_04
    end else begin
      eff_addr = {exec_pkg::SFR_BANK, instr_r[7:0]};
    end
  end

  // Processing of the operand read in the second phase
  always_comb begin
    logic [exec_pkg::DATA_W+2:0] s;
    s = '0;
    result = ram_q;
    flags_nxt = flags_r;
    case (op_r)
      exec_pkg::OP_ROTATE: begin
        result = {ram_q[0], ram_q[7:1]}; // RULE_01
        flags_nxt[exec_pkg::ST_Z] = (result == 8'h00); // RULE_02
        flags_nxt[exec_pkg::ST_N] = result[7]; // RULE_02
      end
      exec_pkg::OP_SET_ONES: begin
        result = exec_pkg::ALL_ONES; // RULE_06
      end
      exec_pkg::OP_SUB_BORROW: begin
        s = sub8(acc_r, ram_q, flags_r[exec_pkg::ST_C]); // RULE_10
        result = s[exec_pkg::DATA_W-1:0];
        flags_nxt = arith_flags(s); // RULE_14
      end
      exec_pkg::OP_SUB_LIT: begin
        s = sub8(instr_r[7:0], acc_r, 1'b1); // RULE_12
        result = s[exec_pkg::DATA_W-1:0];
        flags_nxt = arith_flags(s); // RULE_14
      end
      exec_pkg::OP_SUB_FILE: begin
        s = sub8(ram_q, acc_r, 1'b1); // RULE_13
        result = s[exec_pkg::DATA_W-1:0];
        flags_nxt = arith_flags(s); // RULE_14
      end
      default: begin
        result = ram_q;
      end
    endcase
  end

  // Four-phase sequencing
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      phase_r <= exec_pkg::PH_IDLE;
    end else begin
      case (phase_r)
        exec_pkg::PH_IDLE: begin
          // Instruction writes while asleep are dropped
          if (bus_wr && avs_address_in == exec_pkg::ADDR_INSTR && !sleep_r) begin
            phase_r <= exec_pkg::PH_DECODE; // RULE_15
          end
        end
        exec_pkg::PH_DECODE: phase_r <= exec_pkg::PH_READ; // RULE_15
        exec_pkg::PH_READ: phase_r <= exec_pkg::PH_PROCESS; // RULE_15
        exec_pkg::PH_PROCESS: phase_r <= exec_pkg::PH_WRITE; // RULE_15
        default: phase_r <= exec_pkg::PH_IDLE;
      endcase
    end
  end

  // Instruction word and decoded operation
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      instr_r <= '0;
      op_r <= exec_pkg::OP_NONE;
      eff_addr_r <= '0;
      to_acc_r <= 1'b0;
      to_file_r <= 1'b0;
    end else if (phase_r == exec_pkg::PH_IDLE && bus_wr &&
                 avs_address_in == exec_pkg::ADDR_INSTR && !sleep_r) begin
      instr_r <= avs_writedata_in[exec_pkg::INSTR_W-1:0];
    end else if (phase_r == exec_pkg::PH_DECODE) begin
      op_r <= op_dec;
      eff_addr_r <= eff_addr;
      case (op_dec)
        exec_pkg::OP_SET_ONES: begin
          to_acc_r <= 1'b0;
          to_file_r <= 1'b1;
        end
        exec_pkg::OP_SUB_LIT: begin
          to_acc_r <= 1'b1; // RULE_12
          to_file_r <= 1'b0;
        end
        exec_pkg::OP_ROTATE, exec_pkg::OP_SUB_BORROW, exec_pkg::OP_SUB_FILE: begin
          to_acc_r <= !instr_r[exec_pkg::D_BIT]; // RULE_03
          to_file_r <= instr_r[exec_pkg::D_BIT]; // RULE_03
        end
        default: begin
          to_acc_r <= 1'b0;
          to_file_r <= 1'b0;
        end
      endcase
    end
  end

  // Result held from processing to write-back
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      result_r <= '0;
      flags_nxt_r <= '0;
    end else if (phase_r == exec_pkg::PH_PROCESS) begin
      result_r <= result; // RULE_15
      flags_nxt_r <= flags_nxt;
    end
  end

  // Accumulator
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      acc_r <= '0;
    end else if (phase_r == exec_pkg::PH_WRITE && to_acc_r) begin
      acc_r <= result_r; // RULE_03
    end else if (bus_wr && avs_address_in == exec_pkg::ADDR_ACC) begin
      acc_r <= avs_writedata_in[exec_pkg::DATA_W-1:0];
    end
  end

  // Status flags
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      flags_r <= '0;
    end else if (phase_r == exec_pkg::PH_WRITE) begin
      flags_r <= flags_nxt_r; // RULE_14
    end else if (bus_wr && avs_address_in == exec_pkg::ADDR_STATUS) begin
      flags_r <= avs_writedata_in[FLAG_W-1:0];
    end
  end

  // Addressing configuration
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ext_enable_r <= 1'b0;
      bank_select_register_r <= '0;
      index_base_r <= '0;
      mem_addr_r <= '0;
    end else if (bus_wr) begin
      if (avs_address_in == exec_pkg::ADDR_CTRL) begin
        ext_enable_r <= avs_writedata_in[exec_pkg::CTRL_EXT_BIT];
      end else if (avs_address_in == exec_pkg::ADDR_BANK) begin
        bank_select_register_r <= avs_writedata_in[exec_pkg::BANK_W-1:0];
      end else if (avs_address_in == exec_pkg::ADDR_INDEX) begin
        index_base_r <= avs_writedata_in[exec_pkg::FADDR_W-1:0];
      end else if (avs_address_in == exec_pkg::ADDR_MEM_ADDR) begin
        mem_addr_r <= avs_writedata_in[exec_pkg::FADDR_W-1:0];
      end
    end
  end

  // Sleep entry and wake-up; sleep entry wins over a wake in the same cycle
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sleep_r <= 1'b0;
      powerdown_status_bit_r <= 1'b1;
      timeout_status_bit_r <= 1'b1;
      watchdog_clear_r <= 1'b0;
    end else begin
      watchdog_clear_r <= 1'b0;
      if (phase_r == exec_pkg::PH_WRITE && op_r == exec_pkg::OP_SLEEP) begin
        sleep_r <= 1'b1; // RULE_08
        powerdown_status_bit_r <= 1'b0; // RULE_07
        timeout_status_bit_r <= 1'b1; // RULE_07
        watchdog_clear_r <= 1'b1; // RULE_07
      end else if (bus_wr && avs_address_in == exec_pkg::ADDR_POWER &&
                   avs_writedata_in[exec_pkg::PW_WAKE] && sleep_r) begin
        sleep_r <= 1'b0;
        if (avs_writedata_in[exec_pkg::PW_WAKE_WDT]) begin
          timeout_status_bit_r <= 1'b0; // RULE_09
        end
      end
    end
  end

  // File register memory ports
  assign ram_rd_addr = busy ? eff_addr_r : mem_addr_r;
  assign ram_wr_en = (phase_r == exec_pkg::PH_WRITE && to_file_r) ||
                     (bus_wr && avs_address_in == exec_pkg::ADDR_MEM_DATA);
  assign ram_wr_addr = busy ? eff_addr_r : mem_addr_r;
  assign ram_wr_data = busy ? result_r : avs_writedata_in[exec_pkg::DATA_W-1:0]; // RULE_03

  file_ram u_file_ram (
    .clock_in(clock_in),
    .wr_en_in(ram_wr_en),
    .wr_addr_in(ram_wr_addr),
    .wr_data_in(ram_wr_data),
    .rd_addr_in(ram_rd_addr),
    .rd_data_out(ram_q)
  );

  // Read mux
  always_comb begin
    read_mux = '0;
    if (avs_address_in == exec_pkg::ADDR_CTRL) begin
      read_mux[exec_pkg::CTRL_EXT_BIT] = ext_enable_r;
    end else if (avs_address_in == exec_pkg::ADDR_INSTR) begin
      read_mux[exec_pkg::INSTR_W-1:0] = instr_r;
    end else if (avs_address_in == exec_pkg::ADDR_ACC) begin
      read_mux[exec_pkg::DATA_W-1:0] = acc_r;
    end else if (avs_address_in == exec_pkg::ADDR_STATUS) begin
      read_mux[FLAG_W-1:0] = flags_r;
    end else if (avs_address_in == exec_pkg::ADDR_BANK) begin
      read_mux[exec_pkg::BANK_W-1:0] = bank_select_register_r;
    end else if (avs_address_in == exec_pkg::ADDR_INDEX) begin
      read_mux[exec_pkg::FADDR_W-1:0] = index_base_r;
    end else if (avs_address_in == exec_pkg::ADDR_POWER) begin
      read_mux[exec_pkg::PW_PD_N] = powerdown_status_bit_r;
      read_mux[exec_pkg::PW_TO_N] = timeout_status_bit_r;
      read_mux[exec_pkg::PW_SLEEP] = sleep_r;
    end else if (avs_address_in == exec_pkg::ADDR_MEM_ADDR) begin
      read_mux[exec_pkg::FADDR_W-1:0] = mem_addr_r;
    end else if (avs_address_in == exec_pkg::ADDR_MEM_DATA) begin
      read_mux[exec_pkg::DATA_W-1:0] = ram_q;
    end
  end

  // Two wait cycles on reads so memory data follow the current address
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rd_stage_r <= '0;
      readdata_r <= '0;
    end else if (avs_read_in && !busy) begin
      if (rd_stage_r == exec_pkg::RD_READY) begin
        rd_stage_r <= '0;
      end else begin
        rd_stage_r <= rd_stage_r + 2'h1;
        readdata_r <= read_mux;
      end
    end else begin
      rd_stage_r <= '0;
    end
  end
endmodule : rotate_set_subtract_sleep_exec

// [verif/exec_props.sv]
// Port-level assertions for the execute datapath
`timescale 1ns/1ps
module exec_props (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [exec_pkg::BUS_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [exec_pkg::BUS_DW-1:0] avs_writedata_in,
  input wire logic [exec_pkg::BUS_DW-1:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic sleep_out,
  input wire logic watchdog_clear_out
);
  logic instr_take;
  logic [2:0] busy_cnt_r;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  // Instruction writes while asleep are dropped, so they start no count
  assign instr_take = avs_write_in && !avs_waitrequest_out && !sleep_out &&
                      avs_address_in == exec_pkg::ADDR_INSTR;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      busy_cnt_r <= 3'h0;
    end else if (instr_take) begin
      busy_cnt_r <= 3'h4;
    end else if (busy_cnt_r != 3'h0) begin
      busy_cnt_r <= busy_cnt_r - 3'h1;
    end
  end

  sequence sleep_taken;
    instr_take && avs_writedata_in[15:0] == exec_pkg::OPC_SLEEP;
  endsequence
  sequence enter_sleep;
    !sleep_out [*4] ##1 sleep_out;
  endsequence
  sequence wdt_pulse;
    !watchdog_clear_out [*4] ##1 watchdog_clear_out ##1 !watchdog_clear_out;
  endsequence
  sequence wake_taken;
    avs_write_in && !avs_waitrequest_out && avs_address_in == exec_pkg::ADDR_POWER &&
      avs_writedata_in[exec_pkg::PW_WAKE];
  endsequence

  a_busy_stalls_bus: assert property (
    (busy_cnt_r != 3'h0 && (avs_read_in || avs_write_in)) |-> avs_waitrequest_out)
    else $error("request not stalled during execution");
  a_idle_write_fast: assert property ((avs_write_in && busy_cnt_r == 3'h0)
    |-> !avs_waitrequest_out) else $error("idle write stalled");
  a_read_two_waits: assert property ((avs_read_in && !$past(avs_read_in) && busy_cnt_r == 3'h0)
    |-> avs_waitrequest_out [*2] ##1 !avs_waitrequest_out) else $error("read latency wrong");
  a_sleep_phase_four: assert property (sleep_taken |=> enter_sleep)
    else $error("sleep not entered after four phases");
  a_wdt_clear_pulse: assert property (sleep_taken |=> wdt_pulse)
    else $error("watchdog clear pulse missing");
  a_wdt_with_sleep: assert property ($rose(watchdog_clear_out) |-> $rose(sleep_out))
    else $error("watchdog cleared without sleep entry");
  a_sleep_holds_on: assert property (
    (sleep_out && !avs_writedata_in[exec_pkg::PW_WAKE]) |=> sleep_out)
    else $error("sleep left without wake");
  a_wake_leaves_sleep: assert property ((sleep_out ##0 wake_taken) |=> !sleep_out)
    else $error("wake write ignored");
  cover property (sleep_taken);
endmodule : exec_props

bind rotate_set_subtract_sleep_exec exec_props u_exec_props (
  .clock_in(clock_in),
  .reset_in(reset_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .sleep_out(sleep_out),
  .watchdog_clear_out(watchdog_clear_out)
);

// [verif/rotate_set_subtract_sleep_exec_tb_top.sv]
// Self-checking testbench for the execute datapath
`timescale 1ns/1ps
module rotate_set_subtract_sleep_exec_tb_top;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic sleep_out;
  logic watchdog_clear_out;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  integer seed = 32'h9bf3;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] wdt_pulses = 8'h0;

  rotate_set_subtract_sleep_exec u_rotate_set_subtract_sleep_exec (
    .clock_in(clock_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .sleep_out(sleep_out),
    .watchdog_clear_out(watchdog_clear_out)
  );

  always #2 clock_in = ~clock_in;

  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t port value %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  // One idle edge after each transfer keeps a request from being driven twice in a step
  task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= 1'b1;
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clock_in);
    avs_write_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus_write

  task automatic bus_read(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clock_in);
    avs_read_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus_read

  // Watcher: each completed read is matched against the oldest note
  always @(posedge clock_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && exp_q.size() > 0)
      check_word(avs_readdata_out, exp_q.pop_front(), mask_q.pop_front());
    if (watchdog_clear_out === 1'b1) wdt_pulses <= wdt_pulses + 8'h1;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // Returns {n, ov, z, dc, c, result} for a + ~b + cin
  function automatic logic [12:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] l;
    s = {1'b0, a} + {1'b0, ~b} + {8'h0, ci};
    l = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
    return {s[7], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h0, l[4], s[8], s[7:0]};
  endfunction : sub8

  task automatic run_op(input int op);
    logic [7:0] w, m, k, r, f;
    logic [4:0] st, fl;
    logic d, a, ext;
    logic [3:0] bk;
    logic [11:0] ix, ea;
    logic [12:0] s;
    logic [15:0] ins;
    {w, m, k, f} = $random(seed);
    {st, d, a, ext, bk} = 12'($random(seed));
    ix = 12'($random(seed));
    ea = a ? {bk, f} : (f > 8'h5f) ? {4'hf, f} : ext ? ix + {4'h0, f} : {4'h0, f};
    bus_write(exec_pkg::ADDR_CTRL, {31'h0, ext});
    bus_write(exec_pkg::ADDR_BANK, {28'h0, bk});
    bus_write(exec_pkg::ADDR_INDEX, {20'h0, ix});
    bus_write(exec_pkg::ADDR_MEM_ADDR, {20'h0, ea});
    bus_write(exec_pkg::ADDR_MEM_DATA, {24'h0, m});
    bus_write(exec_pkg::ADDR_ACC, {24'h0, w});
    bus_write(exec_pkg::ADDR_STATUS, {27'h0, st});
    // Readback with full mask so reserved bits must read zero
    bus_read(exec_pkg::ADDR_CTRL, {31'h0, ext}, 32'hffffffff);
    bus_read(exec_pkg::ADDR_BANK, {28'h0, bk}, 32'hffffffff);
    bus_read(exec_pkg::ADDR_INDEX, {20'h0, ix}, 32'hffffffff);
    bus_read(exec_pkg::ADDR_MEM_ADDR, {20'h0, ea}, 32'hffffffff);
    case (op)
      0: s = {st[4:0], m[0], m[7:1]};
      1: s = {st, 8'hff};
      2: s = sub8(w, m, st[0]);
      3: s = sub8(k, w, 1'b1);
      default: s = sub8(m, w, 1'b1);
    endcase
    r = s[7:0];
    fl = s[12:8];
    if (op == 0) fl = {r[7], st[3], r == 8'h0, st[1:0]};
    if (op == 1) d = 1'b1;
    if (op == 3) d = 1'b0;
    case (op)
      0: ins = {exec_pkg::OPC_ROTATE, d, a, f};
      1: ins = {exec_pkg::OPC_SET_ONES, a, f};
      2: ins = {exec_pkg::OPC_SUB_BORROW, d, a, f};
      3: ins = {exec_pkg::OPC_SUB_LIT, k};
      default: ins = {exec_pkg::OPC_SUB_FILE, d, a, f};
    endcase
    bus_write(exec_pkg::ADDR_INSTR, {16'h0, ins});
    bus_read(exec_pkg::ADDR_INSTR, {16'h0, ins}, 32'hffffffff);
    bus_read(exec_pkg::ADDR_ACC, {24'h0, d ? w : r}, 32'hff);
    bus_read(exec_pkg::ADDR_STATUS, {27'h0, fl}, 32'h1f);
    bus_read(exec_pkg::ADDR_MEM_DATA, {24'h0, d ? r : m}, 32'hff);
  endtask : run_op

  initial begin
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    bus_read(exec_pkg::ADDR_ACC, 32'h0, 32'hff);
    bus_read(exec_pkg::ADDR_STATUS, 32'h0, 32'h1f);
    bus_read(exec_pkg::ADDR_POWER, 32'h3, 32'h7);
    bus_write(6'h28, $random(seed));
    bus_read(6'h28, 32'h0, 32'hffffffff);
    $display("test reset and unmapped done");
    for (int i = 0; i < 60; i++) run_op(i % 5);
    $display("test operations done");
    bus_write(exec_pkg::ADDR_ACC, 32'h11);
    // Unknown opcode must leave the accumulator alone
    bus_write(exec_pkg::ADDR_INSTR, 32'hffff);
    bus_read(exec_pkg::ADDR_ACC, 32'h11, 32'hff);
    bus_write(exec_pkg::ADDR_INSTR, {16'h0, exec_pkg::OPC_SLEEP});
    bus_read(exec_pkg::ADDR_POWER, 32'h6, 32'h7);
    check_bit({7'h0, sleep_out}, 8'h1);
    // Sleeping core must drop this instruction
    bus_write(exec_pkg::ADDR_INSTR, {16'h0, exec_pkg::OPC_SUB_LIT, 8'h20});
    bus_read(exec_pkg::ADDR_ACC, 32'h11, 32'hff);
    bus_write(exec_pkg::ADDR_POWER, 32'h8);
    bus_read(exec_pkg::ADDR_POWER, 32'h2, 32'h6);
    bus_write(exec_pkg::ADDR_INSTR, {16'h0, exec_pkg::OPC_SLEEP});
    bus_write(exec_pkg::ADDR_POWER, 32'h18);
    bus_read(exec_pkg::ADDR_POWER, 32'h0, 32'h6);
    check_bit(wdt_pulses, 8'h2);
    $display("test sleep and wake done");
    repeat (4) @(posedge clock_in);
    finish_test();
  end
endmodule : rotate_set_subtract_sleep_exec_tb_top
